//--- logic/iahm_matcher.sv
/*
  iahm_matcher: one access_control_entry IPv4 header matcher with its
  APB configuration registers.
  Assumes header fields arrive from an ingress parser on pclk with a
  one-cycle valid strobe, and an APB master on the same clock.
*/
// Design decisions made here: the APB register port and the address map.
// Operation
// - IPv4 header criteria apply only when entry frame type is IPv4.
// - Protocol any: protocol field does not affect the hit.
// - Protocol specific: frame protocol must equal configured 8-bit value.
// - ICMP, UDP, TCP choices match that protocol and enable its extra checks.
// - TTL zero: frames with TTL above zero never hit.
// - TTL non-zero: frames with TTL above zero may hit.
// - TTL, fragment and options each offer an any setting.
// - Fragment no: frames with MF set or offset nonzero never hit.
// - Fragment yes: frames with MF set or offset nonzero may hit.
// - Options no: frames carrying header options never hit.
// - Options yes: frames carrying header options may hit.
// - Source any: source address ignored.
// - Source host: source address must equal configured address.
// - Source network: source compared with configured address under source mask.
// - Destination any: destination address ignored.
// - Destination host: destination must equal configured address.
// - Destination network: compared with configured address under destination mask.
`timescale 1ns/1ps

module iahm_matcher
	import iahm_pkg::*;
#(
	parameter int PADDR_W = 8
) (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [PADDR_W-1:0] paddr,
	input  wire logic [31:0]        pwdata,
	input  wire logic [3:0]         pstrb,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic               hdr_valid,
	input  wire iahm_hdr_s          hdr,
	output logic                    match_valid,
	output logic                    match_hit,
	output logic      [2:0]         l4_param_en
);

	// ==========================================================
	// elaboration check
	generate
		if (PADDR_W < 5 || PADDR_W > 32) begin : g_bad_addr
			$error("iahm_matcher: PADDR_W must be 5 to 32");
		end
	endgenerate

	// ==========================================================
	// declarations
	iahm_ctrl_s  ctrl_q;
	logic [7:0]  proto_val_q;
	logic [31:0] src_addr_q;
	logic [31:0] source_net_mask_q;
	logic [31:0] dst_addr_q;
	logic [31:0] dest_net_mask_q;
	logic [31:0] hit_count_q;
	logic [31:0] prdata_q;
	logic        last_valid_q;
	logic [7:0]  addr_lo;
	logic        addr_ok;
	logic        wr_en;
	logic        setup;
	logic [31:0] wmask;
	logic [31:0] rd_d;
	logic        proto_ok;
	logic        ttl_ok;
	logic        frag_ok;
	logic        opt_ok;
	logic        src_ok;
	logic        dst_ok;
	logic        ip_ok;
	logic        hit_d;
	logic [2:0]  l4_d;
	logic        fragmented;
	logic        has_options;

	// ==========================================================
	// APB decode
	assign addr_lo = 8'(paddr);
	assign setup   = psel & ~penable;
	assign wr_en   = psel & penable & pwrite & addr_ok;
	assign pready  = psel & penable;
	assign pslverr = psel & penable & ~addr_ok;
	assign prdata  = prdata_q;

	// upper address bits must be zero and word aligned
	always_comb begin
		addr_ok = (paddr >> 5) == '0;
		if (addr_lo[1:0] != 2'h0) begin
			addr_ok = 1'b0;
		end
	end

	// byte enables to a bit mask, one lane per byte
	for (genvar b = 0; b < 4; b++) begin : g_wmask
		assign wmask[b*8 +: 8] = {8{pstrb[b]}};
	end

	// ==========================================================
	// configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q            <= RST_CTRL;
			proto_val_q       <= 8'(RST_WORD);
			src_addr_q        <= RST_WORD;
			source_net_mask_q <= RST_MASK;
			dst_addr_q        <= RST_WORD;
			dest_net_mask_q   <= RST_MASK;
		end else if (wr_en) begin
			unique case (addr_lo)
				OFS_CTRL: begin
					ctrl_q <= (ctrl_q & ~wmask) | (pwdata & wmask & 32'h0000_7FFF);
				end
				OFS_PROTO_VAL: begin
					if (pstrb[0]) begin
						proto_val_q <= pwdata[7:0];
					end
				end
				OFS_SRC_ADDR:  src_addr_q        <= (src_addr_q & ~wmask) | (pwdata & wmask);
				OFS_SRC_MASK:  source_net_mask_q <= (source_net_mask_q & ~wmask) | (pwdata & wmask);
				OFS_DST_ADDR:  dst_addr_q        <= (dst_addr_q & ~wmask) | (pwdata & wmask);
				OFS_DST_MASK:  dest_net_mask_q   <= (dest_net_mask_q & ~wmask) | (pwdata & wmask);
				default: ;
			endcase
		end
	end

	// read mux, captured in setup phase
	always_comb begin
		rd_d = 32'h0000_0000;
		unique case (addr_lo)
			OFS_CTRL:      rd_d = ctrl_q;
			OFS_PROTO_VAL: rd_d = {24'h00_0000, proto_val_q};
			OFS_SRC_ADDR:  rd_d = src_addr_q;
			OFS_SRC_MASK:  rd_d = source_net_mask_q;
			OFS_DST_ADDR:  rd_d = dst_addr_q;
			OFS_DST_MASK:  rd_d = dest_net_mask_q;
			OFS_STATUS:    rd_d = {27'h000_0000, l4_param_en, match_hit, last_valid_q};
			OFS_HIT_COUNT: rd_d = hit_count_q;
			default:       rd_d = 32'h0000_0000;
		endcase
	end

	// read data register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= RST_WORD;
		end else if (setup) begin
			prdata_q <= addr_ok ? rd_d : 32'h0000_0000;
		end
	end

	// ==========================================================
	// header condition decode
	assign fragmented  = hdr.more_frag | (hdr.frag_off != 13'h0000);
	assign has_options = hdr.ihl > IHL_NO_OPTIONS;

	// protocol criterion
	always_comb begin
		proto_ok = 1'b0;
		l4_d     = 3'b000;
		unique case (ctrl_q.proto_mode)
			PR_ANY:      proto_ok = 1'b1;
			PR_SPECIFIC: proto_ok = hdr.proto == proto_val_q;
			PR_ICMP: begin
				proto_ok = hdr.proto == IPPROTO_ICMP;
				l4_d     = 3'b001;
			end
			PR_UDP: begin
				proto_ok = hdr.proto == IPPROTO_UDP;
				l4_d     = 3'b010;
			end
			PR_TCP: begin
				proto_ok = hdr.proto == IPPROTO_TCP;
				l4_d     = 3'b100;
			end
			default:     proto_ok = 1'b0;
		endcase
	end

	// ttl, fragment and options criteria
	always_comb begin
		ttl_ok  = 1'b1;
		frag_ok = 1'b1;
		opt_ok  = 1'b1;
		if (ctrl_q.ttl_mode == TRI_NO) begin
			ttl_ok = hdr.ttl == 8'h00;
		end else if (ctrl_q.ttl_mode == TRI_YES) begin
			ttl_ok = hdr.ttl != 8'h00;
		end
		if (ctrl_q.frag_mode == TRI_NO) begin
			frag_ok = ~fragmented;
		end else if (ctrl_q.frag_mode == TRI_YES) begin
			frag_ok = fragmented;
		end
		if (ctrl_q.opt_mode == TRI_NO) begin
			opt_ok = ~has_options;
		end else if (ctrl_q.opt_mode == TRI_YES) begin
			opt_ok = has_options;
		end
	end

	// address criteria
	always_comb begin
		unique case (ctrl_q.source_addr_criterion)
			AD_ANY:     src_ok = 1'b1;
			AD_HOST:    src_ok = hdr.src == src_addr_q;
			AD_NETWORK: src_ok = (hdr.src & source_net_mask_q) == (src_addr_q & source_net_mask_q);
			default:    src_ok = 1'b0;
		endcase
		unique case (ctrl_q.dest_addr_criterion)
			AD_ANY:     dst_ok = 1'b1;
			AD_HOST:    dst_ok = hdr.dst == dst_addr_q;
			AD_NETWORK: dst_ok = (hdr.dst & dest_net_mask_q) == (dst_addr_q & dest_net_mask_q);
			default:    dst_ok = 1'b0;
		endcase
	end

	// combined decision, gated by frame type
	always_comb begin
		ip_ok = hdr.is_ipv4 & proto_ok & ttl_ok & frag_ok & opt_ok & src_ok & dst_ok;
		hit_d = (ctrl_q.frame_type == FT_IPV4) ? ip_ok : 1'b1;
	end

	// ==========================================================
	// result registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_valid <= 1'b0;
		end else begin
			match_valid <= hdr_valid;
		end
	end

	// hit and layer-4 enables held until next header
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_hit    <= 1'b0;
			l4_param_en  <= 3'b000;
			last_valid_q <= 1'b0;
		end else if (hdr_valid) begin
			match_hit    <= hit_d;
			l4_param_en  <= (ctrl_q.frame_type == FT_IPV4 && hit_d) ? l4_d : 3'b000;
			last_valid_q <= 1'b1;
		end
	end

	// hit counter, write clears, a hit in the same cycle is counted after the clear (count becomes one)
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hit_count_q <= RST_WORD;
		end else if (hdr_valid && hit_d) begin
			hit_count_q <= (wr_en && addr_lo == OFS_HIT_COUNT) ? 32'h0000_0001 : hit_count_q + 32'h0000_0001;
		end else if (wr_en && addr_lo == OFS_HIT_COUNT) begin
			hit_count_q <= RST_WORD;
		end
	end

	// ==========================================================
	// assertions
	property p_ipv4_gate;
		@(posedge pclk) disable iff (!presetn)
		hdr_valid && ctrl_q.frame_type == FT_IPV4 && !hdr.is_ipv4 |=> match_valid && !match_hit;
	endproperty
	a_frame_type_gate: assert property (p_ipv4_gate) else $error("non-IPv4 frame hit an IPv4 entry");

	a_non_ipv4_pass: assert property (@(posedge pclk) disable iff (!presetn)
		hdr_valid && ctrl_q.frame_type != FT_IPV4 |=> match_hit && l4_param_en == 3'b000)
		else $error("non-IPv4 entry did not pass");

	a_proto_specific_miss: assert property (@(posedge pclk) disable iff (!presetn)
		hdr_valid && ctrl_q.frame_type == FT_IPV4 && ctrl_q.proto_mode == PR_SPECIFIC
		&& hdr.proto != proto_val_q |=> !match_hit)
		else $error("protocol mismatch hit");

	a_proto_tcp_enable: assert property (@(posedge pclk) disable iff (!presetn)
		match_valid && l4_param_en[2] |-> match_hit && $past(hdr.proto) == IPPROTO_TCP)
		else $error("tcp enable without tcp frame");

	a_ttl_zero_block: assert property (@(posedge pclk) disable iff (!presetn)
		hdr_valid && ctrl_q.frame_type == FT_IPV4 && ctrl_q.ttl_mode == TRI_NO
		&& hdr.ttl != 8'h00 |=> !match_hit)
		else $error("nonzero ttl hit a zero-ttl entry");

	a_frag_no_block: assert property (@(posedge pclk) disable iff (!presetn)
		hdr_valid && ctrl_q.frame_type == FT_IPV4 && ctrl_q.frag_mode == TRI_NO
		&& (hdr.more_frag || hdr.frag_off != 13'h0000) |=> !match_hit)
		else $error("fragment hit a no-fragment entry");

	a_opt_no_block: assert property (@(posedge pclk) disable iff (!presetn)
		hdr_valid && ctrl_q.frame_type == FT_IPV4 && ctrl_q.opt_mode == TRI_NO
		&& hdr.ihl > IHL_NO_OPTIONS |=> !match_hit)
		else $error("options frame hit a no-options entry");

	a_src_host_miss: assert property (@(posedge pclk) disable iff (!presetn)
		hdr_valid && ctrl_q.frame_type == FT_IPV4 && ctrl_q.source_addr_criterion == AD_HOST
		&& hdr.src != src_addr_q |=> !match_hit)
		else $error("source host mismatch hit");

	a_dst_net_miss: assert property (@(posedge pclk) disable iff (!presetn)
		hdr_valid && ctrl_q.frame_type == FT_IPV4 && ctrl_q.dest_addr_criterion == AD_NETWORK
		&& ((hdr.dst ^ dst_addr_q) & dest_net_mask_q) != 32'h0000_0000 |=> !match_hit)
		else $error("destination network mismatch hit");

	a_all_any_hit: assert property (@(posedge pclk) disable iff (!presetn)
		hdr_valid && hdr.is_ipv4 && ctrl_q[14:2] == 13'h0000 |=> match_valid && match_hit)
		else $error("all-any entry missed an IPv4 frame");

	a_masked_pass: assert property (@(posedge pclk) disable iff (!presetn)
		hdr_valid && ctrl_q.frame_type == FT_IPV4 && hdr.is_ipv4 && ctrl_q[10:2] == 9'h000
		&& ctrl_q.dest_addr_criterion == AD_ANY && ctrl_q.source_addr_criterion == AD_NETWORK
		&& ((hdr.src ^ src_addr_q) & source_net_mask_q) == 32'h0000_0000 |=> match_hit)
		else $error("masked source match missed");

	a_frag_yes_pass: assert property (@(posedge pclk) disable iff (!presetn)
		hdr_valid && hdr.is_ipv4 && ctrl_q.frame_type == FT_IPV4 && ctrl_q[14:9] == 6'h00
		&& ctrl_q[6:2] == 5'h00 && ctrl_q.frag_mode == TRI_YES && fragmented |=> match_hit)
		else $error("fragment missed a fragment entry");

	a_opt_yes_pass: assert property (@(posedge pclk) disable iff (!presetn)
		hdr_valid && hdr.is_ipv4 && ctrl_q.frame_type == FT_IPV4 && ctrl_q[14:11] == 4'h0
		&& ctrl_q[8:2] == 7'h00 && ctrl_q.opt_mode == TRI_YES && has_options |=> match_hit)
		else $error("options frame missed an options entry");

	a_hit_count_step: assert property (@(posedge pclk) disable iff (!presetn)
		hdr_valid && hit_d && !(wr_en && addr_lo == OFS_HIT_COUNT)
		|=> hit_count_q == $past(hit_count_q) + 32'h0000_0001)
		else $error("hit counter did not step on a hit");

	c_ipv4_hit: cover property (@(posedge pclk) disable iff (!presetn)
		match_valid && match_hit && $past(ctrl_q.frame_type) == FT_IPV4);
	c_udp_hit: cover property (@(posedge pclk) disable iff (!presetn) match_valid && l4_param_en[1]);
	c_net_miss: cover property (@(posedge pclk) disable iff (!presetn)
		match_valid && !match_hit && ctrl_q.source_addr_criterion == AD_NETWORK);
	c_slverr: cover property (@(posedge pclk) disable iff (!presetn) pslverr);

endmodule // iahm_matcher

//--- logic/iahm_pkg.sv
/*
  iahm_pkg: constants, register map and carrier types of the IPv4
  access_control_entry header matcher.
  Assumes a 32-bit APB register bus and a parser on the same clock.
*/
package iahm_pkg;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFS_CTRL        = 8'h00;
	localparam logic [7:0] OFS_PROTO_VAL   = 8'h04;
	localparam logic [7:0] OFS_SRC_ADDR    = 8'h08;
	localparam logic [7:0] OFS_SRC_MASK    = 8'h0C;
	localparam logic [7:0] OFS_DST_ADDR    = 8'h10;
	localparam logic [7:0] OFS_DST_MASK    = 8'h14;
	localparam logic [7:0] OFS_STATUS      = 8'h18;
	localparam logic [7:0] OFS_HIT_COUNT   = 8'h1C;

	// ==========================================================
	// reset values
	localparam logic [31:0] RST_CTRL       = 32'h0000_0000;
	localparam logic [31:0] RST_WORD       = 32'h0000_0000;
	localparam logic [31:0] RST_MASK       = 32'hFFFF_FFFF;

	// ==========================================================
	// field codes
	localparam logic [1:0] FT_ANY          = 2'h0;
	localparam logic [1:0] FT_IPV4         = 2'h1;
	localparam logic [2:0] PR_ANY          = 3'h0;
	localparam logic [2:0] PR_SPECIFIC     = 3'h1;
	localparam logic [2:0] PR_ICMP         = 3'h2;
	localparam logic [2:0] PR_UDP          = 3'h3;
	localparam logic [2:0] PR_TCP          = 3'h4;
	localparam logic [1:0] TRI_ANY         = 2'h0;
	localparam logic [1:0] TRI_NO          = 2'h1;
	localparam logic [1:0] TRI_YES         = 2'h2;
	localparam logic [1:0] AD_ANY          = 2'h0;
	localparam logic [1:0] AD_HOST         = 2'h1;
	localparam logic [1:0] AD_NETWORK      = 2'h2;

	// ==========================================================
	// protocol numbers and header limits
	localparam logic [7:0] IPPROTO_ICMP    = 8'h01;
	localparam logic [7:0] IPPROTO_TCP     = 8'h06;
	localparam logic [7:0] IPPROTO_UDP     = 8'h11;
	localparam logic [3:0] IHL_NO_OPTIONS  = 4'h5;

	// ==========================================================
	// control register layout, bit 0 upward from the right
	typedef struct packed {
		logic [16:0] rsvd;
		logic [1:0]  dest_addr_criterion;
		logic [1:0]  source_addr_criterion;
		logic [1:0]  opt_mode;
		logic [1:0]  frag_mode;
		logic [1:0]  ttl_mode;
		logic [2:0]  proto_mode;
		logic [1:0]  frame_type;
	} iahm_ctrl_s;

	// parsed IPv4 header fields from ingress
	typedef struct packed {
		logic        is_ipv4;
		logic [3:0]  ihl;
		logic [7:0]  ttl;
		logic        more_frag;
		logic [12:0] frag_off;
		logic [7:0]  proto;
		logic [31:0] src;
		logic [31:0] dst;
	} iahm_hdr_s;

endpackage

//--- testbench/iahm_parser_model.sv
/*
  iahm_parser_model: ingress parser stand-in that presents one IPv4 header per request.
  Assumes requests arrive on pclk by non-blocking assignment, one cycle long.
*/
`timescale 1ns/1ps

module iahm_parser_model
	import iahm_pkg::*;
(
	input  wire logic      pclk,
	input  wire logic      presetn,
	input  wire logic      send,
	input  wire iahm_hdr_s hdr_in,
	output logic           hdr_valid,
	output iahm_hdr_s      hdr
);
	// ==========================================================
	// strobe one header; fields invert each idle cycle, so the last header returns every second idle cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hdr_valid <= 1'b0;
			hdr       <= '0;
		end else begin
			hdr_valid <= send;
			hdr       <= send ? hdr_in : ~hdr;
		end
	end
endmodule // iahm_parser_model

//--- testbench/test_ipv4_ace_header_matcher.sv
/*
  test_ipv4_ace_header_matcher: self-checking bench for the header matcher.
  Assumes the matcher answers APB with zero wait states and a result one cycle after each header.
*/
`timescale 1ns/1ps

module test_ipv4_ace_header_matcher;
	import iahm_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, er_v, send;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd_v;
	logic [3:0]  pstrb;
	logic        pready, pslverr, hdr_valid, match_valid, match_hit;
	logic [2:0]  l4_param_en;
	iahm_hdr_s   hdr, hdr_in, base;
	int          err_count, n_checks;

	iahm_matcher #(.PADDR_W(8)) iahm_matcher_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .hdr_valid(hdr_valid), .hdr(hdr), .match_valid(match_valid),
		.match_hit(match_hit), .l4_param_en(l4_param_en));
	iahm_parser_model iahm_parser_model_inst (.pclk(pclk), .presetn(presetn), .send(send), .hdr_in(hdr_in),
		.hdr_valid(hdr_valid), .hdr(hdr));

	// ==========================================================
	// clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// ==========================================================
	// shared tasks
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin err_count++; report_and_stop; end
		rd_v = prdata;
		er_v = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	function automatic logic [31:0] cf(input logic [1:0] ft, input logic [2:0] pr, input logic [31:0] ex);
		return {27'h0, pr, ft} | ex;
	endfunction

	// one header through the parser model, then judge hit and extra-check enables
	task hit(input iahm_hdr_s h, input logic exp, input logic [2:0] l4);
		int n;
		@(posedge pclk);
		send <= 1'b1; hdr_in <= h;
		@(posedge pclk);
		send <= 1'b0;
		n = 0;
		do begin @(posedge pclk); #1; n++; end while (match_valid !== 1'b1 && n < 8);
		if (match_valid !== 1'b1) begin err_count++; report_and_stop; end
		check(32'(match_hit), 32'(exp));
		check(32'(l4_param_en), 32'(l4));
	endtask

	// ==========================================================
	// scenarios
	task t_reset;
		apb(1'b0, OFS_CTRL, 32'h0); check(rd_v, RST_CTRL);
		apb(1'b0, OFS_DST_MASK, 32'h0); check(rd_v, RST_MASK);
		apb(1'b0, 8'h20, 32'h0); check({rd_v[30:0], er_v}, 32'h1);
	endtask

	task t_frame;
		iahm_hdr_s h;
		h = base;
		h.is_ipv4 = 1'b0;
		wr(OFS_CTRL, cf(FT_ANY, PR_ANY, 32'(TRI_NO) << 5));
		hit(base, 1'b1, 3'h0);
		hit(h, 1'b1, 3'h0);
		wr(OFS_CTRL, cf(FT_IPV4, PR_ANY, 32'(TRI_NO) << 5));
		hit(base, 1'b0, 3'h0);
		hit(h, 1'b0, 3'h0);
	endtask

	task t_proto;
		iahm_hdr_s h;
		logic [7:0] pn [3];
		pn = '{IPPROTO_ICMP, IPPROTO_UDP, IPPROTO_TCP};
		h = base;
		wr(OFS_PROTO_VAL, 32'hFF);
		wr(OFS_CTRL, cf(FT_IPV4, PR_SPECIFIC, 32'h0));
		h.proto = 8'hFF; hit(h, 1'b1, 3'h0);
		h.proto = 8'hFE; hit(h, 1'b0, 3'h0);
		wr(OFS_CTRL, cf(FT_IPV4, PR_ANY, 32'h0));
		hit(h, 1'b1, 3'h0);
		for (int i = 0; i < 3; i++) begin
			wr(OFS_CTRL, cf(FT_IPV4, PR_ICMP + 3'(i), 32'h0));
			h.proto = pn[i]; hit(h, 1'b1, 3'(1 << i));
			h.proto = pn[(i + 1) % 3]; hit(h, 1'b0, 3'h0);
		end
	endtask

	// ttl, fragment (flag, then offset) and options: every mode against both header states
	task t_tri;
		iahm_hdr_s h;
		int sh;
		for (int f = 0; f < 4; f++) for (int m = 0; m < 3; m++) for (int v = 0; v < 2; v++) begin
			sh = (f == 3) ? 7 : 5 + 2 * f;
			wr(OFS_CTRL, cf(FT_IPV4, PR_ANY, 32'(m) << sh));
			h = base;
			case (f)
				0: h.ttl = v ? 8'h01 : 8'h00;
				1: h.more_frag = 1'(v);
				2: h.ihl = v ? 4'h6 : IHL_NO_OPTIONS;
				default: h.frag_off = 13'(v);
			endcase
			hit(h, (m == 0) || (m == 1 ? v == 0 : v == 1), 3'h0);
		end
	endtask

	task hs(input int s, input logic [31:0] v, input logic exp);
		iahm_hdr_s h;
		h = base;
		if (s == 1) h.dst = v;
		else h.src = v;
		hit(h, exp, 3'h0);
	endtask

	task t_addr;
		for (int s = 0; s < 2; s++) begin
			wr(OFS_SRC_ADDR + 8'(8 * s), 32'hC0A80101);
			wr(OFS_SRC_MASK + 8'(8 * s), 32'hFFFFFF00);
			wr(OFS_CTRL, cf(FT_IPV4, PR_ANY, 32'(AD_HOST) << (11 + 2 * s)));
			hs(s, 32'hC0A80101, 1'b1);
			hs(s, 32'hC0A80100, 1'b0);
			wr(OFS_CTRL, cf(FT_IPV4, PR_ANY, 32'(AD_NETWORK) << (11 + 2 * s)));
			hs(s, 32'hC0A801FE, 1'b1);
			hs(s, 32'hC0A80301, 1'b0);
			wr(OFS_CTRL, cf(FT_IPV4, PR_ANY, 32'h0));
			hs(s, 32'hC0A80301, 1'b1);
		end
	endtask

	task t_all;
		iahm_hdr_s h;
		h = base;
		h.proto = IPPROTO_UDP; h.src = 32'hC0A80101; h.dst = 32'hC0A80177;
		wr(OFS_CTRL, cf(FT_IPV4, PR_UDP, (32'(TRI_YES) << 5) | (32'(TRI_NO) << 7) | (32'(TRI_NO) << 9)
			| (32'(AD_HOST) << 11) | (32'(AD_NETWORK) << 13)));
		wr(OFS_HIT_COUNT, 32'h0);
		hit(h, 1'b1, 3'h2);
		apb(1'b0, OFS_STATUS, 32'h0); check(rd_v, 32'h0000_000B);
		apb(1'b0, OFS_HIT_COUNT, 32'h0); check(rd_v, 32'h0000_0001);
		h.ttl = 8'h00; hit(h, 1'b0, 3'h0);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
		pstrb = 4'hF; send = 1'b0; hdr_in = '0; err_count = 0; n_checks = 0;
		base = '{1'b1, IHL_NO_OPTIONS, 8'h40, 1'b0, 13'h0, 8'h33, 32'h0A000001, 32'h0A000002};
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_frame;
		t_proto;
		t_tri;
		t_addr;
		t_all;
		report_and_stop;
	end
endmodule // test_ipv4_ace_header_matcher
